// ===== inc/txawg_pkg.sv
package txawg_pkg;

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] OFS_RAM_CTRL = 8'h00;
    localparam logic [7:0] OFS_RAM_DATA = 8'h04;
    localparam logic [7:0] OFS_SHAPE    = 8'h08;
    localparam logic [7:0] OFS_GAIN     = 8'h0C;
    localparam logic [7:0] OFS_TXCFG0   = 8'h10;
    localparam logic [7:0] OFS_LINE_ST  = 8'h14;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_IRQ_EDGE = 8'h20;
    localparam logic [7:0] OFS_TPL_LOAD = 8'h24;

    // ==========================================================
    // field positions
    localparam int IDX_MSB   = 4;
    localparam int DIR_BIT   = 5;
    localparam int GO_BIT    = 6;
    localparam int AMP_MSB   = 6;
    localparam int USER_BIT  = 3;
    localparam int TPL_MSB   = 2;
    localparam int GAIN_MSB  = 5;
    localparam int DRVEN_BIT = 6;
    localparam int TRIOC_BIT = 4;
    localparam int SING_BIT  = 3;
    localparam int OC_BIT    = 4;
    localparam int OVF_BIT   = 7;

    // ==========================================================
    // waveform geometry and reset values
    localparam int          NUM_PHASES  = 20;
    localparam int          UI_PHASES   = 16;
    localparam int          TAIL_PHASES = 4;
    localparam int          NUM_TPL     = 8;
    localparam int          AMP_MAX     = 63;
    localparam logic [5:0]  GAIN_RST    = 6'h36;
    localparam logic [3:0]  SHAPE_RST   = 4'h0;

    typedef struct packed {
        logic drv_en;
        logic tri_oc;
        logic single_ended;
    } txawg_txcfg_s;

    localparam txawg_txcfg_s TXCFG_RST = '{drv_en: 1'b1, tri_oc: 1'b0, single_ended: 1'b0};

    typedef enum logic [1:0] {
        TXAWG_ACC_IDLE = 2'b00,
        TXAWG_ACC_RUN  = 2'b01
    } txawg_acc_e;

    // ==========================================================
    // standard sample sets, sample 1 in the low byte
    localparam logic [159:0] TPL_ROM [NUM_TPL] = '{
        160'h0000_4142_4344_4547_494A_4A23_2425_2525_2627_2717,
        160'h0041_4243_4446_484A_4D4F_5025_2627_2829_2A2C_2E1B,
        160'h0041_4243_4446_484B_5053_5725_2829_2A2B_2C2F_341F,
        160'h0041_4243_4446_484C_5358_5828_2A2C_2D2E_2F35_3B20,
        160'h0041_4243_4447_494F_575E_5F29_2C2D_2E2F_3338_3F20,
        160'h30_0C00_0000,
        160'h3C_0F00_0000,
        160'h0000_4142_4344_4547_494A_4A23_2425_2525_2627_2717
    };

    function automatic logic signed [7:0] sm_to_signed(input logic [6:0] v);
        logic signed [7:0] m;
        m = signed'({2'h0, v[AMP_MSB-1:0]});
        return v[AMP_MSB] ? -m : m;
    endfunction

endpackage

// ===== logic/txawg_ctrl.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

// Contract
// - shape select 1XXX uses user waveform memory
// - twenty sub-phases addressed by five-bit index
// - amplitudes are seven-bit signed magnitude
// - eight read-only standard sample sets
// - go with direction zero stores data amplitude
// - go with direction one returns stored amplitude
// - gain field scales transmitted amplitude
// - summed overlap beyond maximum sets overflow flag
// - overflow interrupt only when enabled
// - global enable pin low tristates driver
// - driver enable bit clear tristates channel
// - tristate leaves internal logic running
// - over-current limits or tristates per bit
// - line status shows present over-current
// - over-current flag on rising or any edge
// - over-current flag drives interrupt unless masked
// - single-ended uses positive pin only
module txawg_ctrl #(
    parameter int PHASE_DIV = 4
) (
    input  wire logic        i_mclk,           // 10 MHz clock
    input  wire logic        i_srst,           // sync reset, high
    input  wire logic        i_psel,           // apb select
    input  wire logic        i_penable,        // apb enable
    input  wire logic        i_pwrite,         // apb direction
    input  wire logic [7:0]  i_paddr,          // apb byte address
    input  wire logic [31:0] i_pwdata,         // apb write data
    output logic      [31:0] o_prdata,         // apb read data
    output logic             o_pready,         // apb ready
    output logic             o_pslverr,        // apb error, unmapped
    input  wire logic        i_tx_mark,        // line bit, sampled per ui
    input  wire logic        i_oe_pin,         // global output enable pin
    input  wire logic        i_tx_overcurrent, // driver over-current sense
    output logic      [12:0] o_dac_level,      // signed scaled amplitude
    output logic             o_line_p_oe,      // positive pin drive
    output logic             o_line_n_oe,      // negative pin drive
    output logic             o_current_limit,  // limit output current
    output logic             o_irq             // interrupt, high level
);

    // ==========================================================
    // pin synchronisers
    logic oe_m_r, oe_s_r, oc_m_r, oc_s_r, oc_d_r;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            oe_m_r <= 1'b0;
            oe_s_r <= 1'b0;
            oc_m_r <= 1'b0;
            oc_s_r <= 1'b0;
            oc_d_r <= 1'b0;
        end else begin
            oe_m_r <= i_oe_pin;
            oe_s_r <= oe_m_r;
            oc_m_r <= i_tx_overcurrent;
            oc_s_r <= oc_m_r;
            oc_d_r <= oc_s_r;
        end
    end

    // ==========================================================
    // apb slave and registers
    logic [4:0]             idx_r, idx_nxt;
    logic                   dir_r, dir_nxt;
    txawg_pkg::txawg_acc_e  acc_r, acc_nxt;
    logic [6:0]             data_r, data_nxt;
    logic [6:0]             ram_r [txawg_pkg::NUM_PHASES];
    logic [6:0]             ram_nxt [txawg_pkg::NUM_PHASES];
    logic [3:0]             shape_r, shape_nxt;
    logic [5:0]             gain_r, gain_nxt;
    logic [2:0]             tpl_r, tpl_nxt;
    txawg_pkg::txawg_txcfg_s cfg_r, cfg_nxt;
    logic [7:0]             flag_r, flag_nxt;
    logic [7:0]             mask_r, mask_nxt;
    logic [7:0]             edge_r, edge_nxt;
    logic [31:0]            prdata_nxt;
    logic                   pready_nxt, pslverr_nxt, irq_nxt;
    logic                   wr_en, setup, hit;
    logic                   ovf_hit, tick;
    logic [6:0]             rd_word;

    assign setup   = i_psel && !i_penable;
    assign wr_en   = i_psel && i_penable && o_pready && i_pwrite;
    assign rd_word = ram_r[idx_r];

    always_comb begin
        hit = 1'b1;
        prdata_nxt = '0;
        if (i_paddr == txawg_pkg::OFS_RAM_CTRL) begin
            prdata_nxt[txawg_pkg::GO_BIT] = (acc_r == txawg_pkg::TXAWG_ACC_RUN);
            prdata_nxt[txawg_pkg::DIR_BIT] = dir_r;
            prdata_nxt[txawg_pkg::IDX_MSB:0] = idx_r;
        end else if (i_paddr == txawg_pkg::OFS_RAM_DATA) begin
            prdata_nxt[txawg_pkg::AMP_MSB:0] = data_r;
        end else if (i_paddr == txawg_pkg::OFS_SHAPE) begin
            prdata_nxt[txawg_pkg::USER_BIT:0] = shape_r;
        end else if (i_paddr == txawg_pkg::OFS_GAIN) begin
            prdata_nxt[txawg_pkg::GAIN_MSB:0] = gain_r;
        end else if (i_paddr == txawg_pkg::OFS_TXCFG0) begin
            prdata_nxt[txawg_pkg::DRVEN_BIT] = cfg_r.drv_en;
            prdata_nxt[txawg_pkg::TRIOC_BIT] = cfg_r.tri_oc;
            prdata_nxt[txawg_pkg::SING_BIT] = cfg_r.single_ended;
        end else if (i_paddr == txawg_pkg::OFS_LINE_ST) begin
            prdata_nxt[txawg_pkg::OC_BIT] = oc_s_r;
        end else if (i_paddr == txawg_pkg::OFS_IRQ_FLAG) begin
            prdata_nxt[7:0] = flag_r;
        end else if (i_paddr == txawg_pkg::OFS_IRQ_MASK) begin
            prdata_nxt[7:0] = mask_r;
        end else if (i_paddr == txawg_pkg::OFS_IRQ_EDGE) begin
            prdata_nxt[7:0] = edge_r;
        end else if (i_paddr == txawg_pkg::OFS_TPL_LOAD) begin
            prdata_nxt[txawg_pkg::TPL_MSB:0] = tpl_r;
        end else begin
            hit = 1'b0;
        end
        // zero-wait slave: ready in the first access cycle
        pready_nxt  = setup;
        pslverr_nxt = setup && !hit;
        if (!setup) begin
            prdata_nxt = o_prdata;
        end
    end

    always_comb begin
        idx_nxt   = idx_r;
        dir_nxt   = dir_r;
        acc_nxt   = acc_r;
        data_nxt  = data_r;
        ram_nxt   = ram_r;
        shape_nxt = shape_r;
        gain_nxt  = gain_r;
        tpl_nxt   = tpl_r;
        cfg_nxt   = cfg_r;
        mask_nxt  = mask_r;
        edge_nxt  = edge_r;
        flag_nxt  = flag_r;
        if (wr_en) begin
            if (i_paddr == txawg_pkg::OFS_RAM_CTRL) begin
                idx_nxt = i_pwdata[txawg_pkg::IDX_MSB:0];
                dir_nxt = i_pwdata[txawg_pkg::DIR_BIT];
                if (i_pwdata[txawg_pkg::GO_BIT] && acc_r == txawg_pkg::TXAWG_ACC_IDLE) begin
                    acc_nxt = txawg_pkg::TXAWG_ACC_RUN;
                end
            end else if (i_paddr == txawg_pkg::OFS_RAM_DATA) begin
                data_nxt = i_pwdata[txawg_pkg::AMP_MSB:0];
            end else if (i_paddr == txawg_pkg::OFS_SHAPE) begin
                shape_nxt = i_pwdata[txawg_pkg::USER_BIT:0];
            end else if (i_paddr == txawg_pkg::OFS_GAIN) begin
                gain_nxt = i_pwdata[txawg_pkg::GAIN_MSB:0];
            end else if (i_paddr == txawg_pkg::OFS_TXCFG0) begin
                cfg_nxt.drv_en       = i_pwdata[txawg_pkg::DRVEN_BIT];
                cfg_nxt.tri_oc       = i_pwdata[txawg_pkg::TRIOC_BIT];
                cfg_nxt.single_ended = i_pwdata[txawg_pkg::SING_BIT];
            end else if (i_paddr == txawg_pkg::OFS_IRQ_FLAG) begin
                flag_nxt = flag_r & ~i_pwdata[7:0];
            end else if (i_paddr == txawg_pkg::OFS_IRQ_MASK) begin
                mask_nxt = i_pwdata[7:0];
            end else if (i_paddr == txawg_pkg::OFS_IRQ_EDGE) begin
                edge_nxt = i_pwdata[7:0];
            end else if (i_paddr == txawg_pkg::OFS_TPL_LOAD) begin
                // whole set copied at once as the editing reference
                tpl_nxt = i_pwdata[txawg_pkg::TPL_MSB:0];
                for (int k = 0; k < txawg_pkg::NUM_PHASES; k++) begin
                    ram_nxt[k] = txawg_pkg::TPL_ROM[tpl_nxt][8*k +: 7];
                end
            end
        end
        // indirect access runs one cycle after go; out-of-range index is a no-op
        case (acc_r)
            txawg_pkg::TXAWG_ACC_RUN: begin
                if (idx_r < 5'(txawg_pkg::NUM_PHASES)) begin
                    if (dir_r) begin
                        data_nxt = rd_word;
                    end else begin
                        ram_nxt[idx_r] = data_r;
                    end
                end
                acc_nxt = txawg_pkg::TXAWG_ACC_IDLE;
            end
            default: begin
                acc_nxt = acc_nxt;
            end
        endcase
        // hardware set wins over a same-cycle clear
        if (ovf_hit && tick) begin
            flag_nxt[txawg_pkg::OVF_BIT] = 1'b1;
        end
        if (edge_r[txawg_pkg::OC_BIT] ? (oc_s_r ^ oc_d_r) : (oc_s_r && !oc_d_r)) begin
            flag_nxt[txawg_pkg::OC_BIT] = 1'b1;
        end
        irq_nxt = |(flag_nxt & mask_nxt);
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            idx_r     <= '0;
            dir_r     <= 1'b0;
            acc_r     <= txawg_pkg::TXAWG_ACC_IDLE;
            data_r    <= '0;
            ram_r     <= '{default: '0};
            shape_r   <= txawg_pkg::SHAPE_RST;
            gain_r    <= txawg_pkg::GAIN_RST;
            tpl_r     <= '0;
            cfg_r     <= txawg_pkg::TXCFG_RST;
            flag_r    <= '0;
            mask_r    <= '0;
            edge_r    <= '0;
            o_prdata  <= '0;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_irq     <= 1'b0;
        end else begin
            idx_r     <= idx_nxt;
            dir_r     <= dir_nxt;
            acc_r     <= acc_nxt;
            data_r    <= data_nxt;
            ram_r     <= ram_nxt;
            shape_r   <= shape_nxt;
            gain_r    <= gain_nxt;
            tpl_r     <= tpl_nxt;
            cfg_r     <= cfg_nxt;
            flag_r    <= flag_nxt;
            mask_r    <= mask_nxt;
            edge_r    <= edge_nxt;
            o_prdata  <= prdata_nxt;
            o_pready  <= pready_nxt;
            o_pslverr <= pslverr_nxt;
            o_irq     <= irq_nxt;
        end
    end

    // ==========================================================
    // pulse engine: 16 phases per ui, 4-phase tail overlaps next ui
    logic [$clog2(PHASE_DIV+1)-1:0] div_r, div_nxt;
    logic [3:0]                     ph_r, ph_nxt;
    logic                           cur_r, cur_nxt, cur_neg_r, cur_neg_nxt;
    logic                           prv_r, prv_nxt, prv_neg_r, prv_neg_nxt;
    logic                           pol_r, pol_nxt;
    logic [6:0]                     smp_cur, smp_tail;
    logic [4:0]                     tail_idx;
    logic signed [7:0]              a_cur, a_tail, clip;
    logic signed [8:0]              sum;
    logic signed [14:0]             scaled;
    logic [12:0]                    level_nxt;
    logic                           p_oe_nxt, n_oe_nxt, limit_nxt, drive;

    assign tick = (div_r == ($bits(div_r))'(PHASE_DIV - 1));

    always_comb begin
        tail_idx = 5'({1'b0, ph_r} + 5'(txawg_pkg::UI_PHASES));
        if (shape_r[txawg_pkg::USER_BIT]) begin
            smp_cur  = ram_r[ph_r];
            smp_tail = ram_r[tail_idx];
        end else begin
            smp_cur  = txawg_pkg::TPL_ROM[shape_r[txawg_pkg::TPL_MSB:0]][8*ph_r +: 7];
            smp_tail = txawg_pkg::TPL_ROM[shape_r[txawg_pkg::TPL_MSB:0]][8*tail_idx +: 7];
        end
        a_cur  = cur_r ? txawg_pkg::sm_to_signed(smp_cur) : 8'sh00;
        a_tail = (prv_r && ph_r < 4'(txawg_pkg::TAIL_PHASES))
               ? txawg_pkg::sm_to_signed(smp_tail) : 8'sh00;
        if (cur_neg_r) begin
            a_cur = -a_cur;
        end
        if (prv_neg_r) begin
            a_tail = -a_tail;
        end
        sum = 9'(a_cur) + 9'(a_tail);
        ovf_hit = (sum > 9'(txawg_pkg::AMP_MAX)) || (sum < -9'(txawg_pkg::AMP_MAX));
        if (sum > 9'(txawg_pkg::AMP_MAX)) begin
            clip = 8'(txawg_pkg::AMP_MAX);
        end else if (sum < -9'(txawg_pkg::AMP_MAX)) begin
            clip = -8'(txawg_pkg::AMP_MAX);
        end else begin
            clip = 8'(sum);
        end
        scaled    = 15'(clip) * signed'({9'h000, gain_r});
        level_nxt = tick ? scaled[12:0] : o_dac_level;
        div_nxt     = tick ? '0 : div_r + 1'b1;
        ph_nxt      = ph_r;
        cur_nxt     = cur_r;
        cur_neg_nxt = cur_neg_r;
        prv_nxt     = prv_r;
        prv_neg_nxt = prv_neg_r;
        pol_nxt     = pol_r;
        if (tick) begin
            ph_nxt = ph_r + 1'b1;
            if (ph_r == 4'(txawg_pkg::UI_PHASES - 1)) begin
                prv_nxt     = cur_r;
                prv_neg_nxt = cur_neg_r;
                cur_nxt     = i_tx_mark;
                cur_neg_nxt = pol_r;
                pol_nxt     = pol_r ^ i_tx_mark;
            end
        end
        // output gating only; the engine above keeps running
        drive     = oe_s_r && cfg_r.drv_en && !(oc_s_r && cfg_r.tri_oc);
        p_oe_nxt  = drive;
        n_oe_nxt  = drive && !cfg_r.single_ended;
        limit_nxt = oc_s_r && !cfg_r.tri_oc;
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            div_r           <= '0;
            ph_r            <= '0;
            cur_r           <= 1'b0;
            cur_neg_r       <= 1'b0;
            prv_r           <= 1'b0;
            prv_neg_r       <= 1'b0;
            pol_r           <= 1'b0;
            o_dac_level     <= '0;
            o_line_p_oe     <= 1'b0;
            o_line_n_oe     <= 1'b0;
            o_current_limit <= 1'b0;
        end else begin
            div_r           <= div_nxt;
            ph_r            <= ph_nxt;
            cur_r           <= cur_nxt;
            cur_neg_r       <= cur_neg_nxt;
            prv_r           <= prv_nxt;
            prv_neg_r       <= prv_neg_nxt;
            pol_r           <= pol_nxt;
            o_dac_level     <= level_nxt;
            o_line_p_oe     <= p_oe_nxt;
            o_line_n_oe     <= n_oe_nxt;
            o_current_limit <= limit_nxt;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    sequence s_go_write;
        acc_r == txawg_pkg::TXAWG_ACC_RUN && !dir_r && idx_r < 5'(txawg_pkg::NUM_PHASES);
    endsequence
    sequence s_go_read;
        acc_r == txawg_pkg::TXAWG_ACC_RUN && dir_r && idx_r < 5'(txawg_pkg::NUM_PHASES);
    endsequence
    sequence s_stat_setup;
        setup && !i_pwrite && i_paddr == txawg_pkg::OFS_LINE_ST;
    endsequence

    a_ram_write_store: assert property (s_go_write |=> ram_r[$past(idx_r)] == $past(data_r))
        else $error("sample write not stored");
    a_ram_read_load: assert property (s_go_read |=> data_r == $past(rd_word))
        else $error("sample read not returned");
    a_go_self_clear: assert property (acc_r == txawg_pkg::TXAWG_ACC_RUN |=> acc_r == txawg_pkg::TXAWG_ACC_IDLE)
        else $error("go bit did not clear");
    a_ovf_flag_set: assert property (ovf_hit && tick |=> flag_r[txawg_pkg::OVF_BIT])
        else $error("overflow not flagged");
    a_irq_gating: assert property (o_irq == |(flag_r & mask_r))
        else $error("interrupt mismatch with flags and mask");
    a_global_hiz: assert property (!oe_s_r |=> !o_line_p_oe && !o_line_n_oe)
        else $error("driver active with enable pin low");
    a_chan_hiz: assert property (!cfg_r.drv_en |=> !o_line_p_oe && !o_line_n_oe)
        else $error("driver active with channel disabled");
    a_oc_response: assert property (oc_s_r |=> cfg_r.tri_oc == $past(cfg_r.tri_oc) |->
        (o_current_limit != $past(cfg_r.tri_oc)) && !(o_line_p_oe && $past(cfg_r.tri_oc)))
        else $error("over-current response wrong");
    a_oc_status_read: assert property (s_stat_setup |=> o_prdata[txawg_pkg::OC_BIT] == $past(oc_s_r))
        else $error("line status does not show over-current");
    a_oc_rise_flag: assert property (oc_s_r && !oc_d_r |=> flag_r[txawg_pkg::OC_BIT])
        else $error("over-current edge not flagged");
    a_single_ended: assert property (cfg_r.single_ended |=> !o_line_n_oe)
        else $error("negative pin driven in single-ended mode");
    a_flag_sticky: assert property (flag_r[txawg_pkg::OVF_BIT] && !wr_en |=> flag_r[txawg_pkg::OVF_BIT])
        else $error("overflow flag dropped without a clear");

endmodule

// ===== verif/test_tx_arbitrary_waveform_driver_ctrl.sv
`timescale 1ns/10ps
module test_tx_arbitrary_waveform_driver_ctrl;
    logic        i_mclk, i_srst, i_psel, i_penable, i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic        o_pready, o_pslverr, er, i_tx_mark, i_oe_pin, i_tx_overcurrent;
    logic        o_line_p_oe, o_line_n_oe, o_current_limit, o_irq;
    logic [12:0] o_dac_level;
    int          failures, total_checks;

    txawg_ctrl #(.PHASE_DIV(1)) txawg_ctrl_inst (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_tx_mark(i_tx_mark),
        .i_oe_pin(i_oe_pin), .i_tx_overcurrent(i_tx_overcurrent), .o_dac_level(o_dac_level),
        .o_line_p_oe(o_line_p_oe), .o_line_n_oe(o_line_n_oe),
        .o_current_limit(o_current_limit), .o_irq(o_irq));

    // ==========================================================
    // shared bus and compare tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // the master waits for pready with no assumed latency, capped by a local limit
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_mclk);
        i_psel    <= 1'b1;
        i_pwrite  <= wr;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        er = o_pslverr;
        chk("pready", 1, (n < 20));
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (4) @(posedge i_mclk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        apb(0, txawg_pkg::OFS_GAIN, 0);
        chk("gain_reset", 32'h0000_0036, rd);
        apb(0, 8'h40, 0);
        chk("unmapped_err", 1, er);
    endtask

    task automatic t_ram();
        logic [6:0] v [2] = '{7'h3F, 7'h7F};
        logic [4:0] ix [2] = '{5'd19, 5'd0};
        for (int k = 0; k < 2; k++) begin
            apb(1, txawg_pkg::OFS_RAM_DATA, {25'h0, v[k]});
            apb(1, txawg_pkg::OFS_RAM_CTRL, {25'h0, 2'b10, ix[k]});
            apb(0, txawg_pkg::OFS_RAM_CTRL, 0);
            chk("go_cleared", 0, rd[6]);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1, txawg_pkg::OFS_RAM_DATA, 0);
            apb(1, txawg_pkg::OFS_RAM_CTRL, {25'h0, 2'b11, ix[k]});
            apb(0, txawg_pkg::OFS_RAM_DATA, 0);
            chk("ram_readback", {25'h0, v[k]}, rd);
        end
    endtask

    task automatic t_drive();
        chk("diff_pair", 2'b11, {o_line_p_oe, o_line_n_oe});
        apb(1, txawg_pkg::OFS_TXCFG0, 32'h0000_0048);
        settle();
        chk("single_ended", 2'b10, {o_line_p_oe, o_line_n_oe});
        apb(1, txawg_pkg::OFS_TXCFG0, 32'h0000_0000);
        settle();
        chk("chan_hiz", 2'b00, {o_line_p_oe, o_line_n_oe});
        apb(0, txawg_pkg::OFS_TXCFG0, 0);
        chk("regs_alive", 0, rd);
        apb(1, txawg_pkg::OFS_TXCFG0, 32'h0000_0040);
        i_oe_pin <= 1'b0;
        settle();
        chk("global_hiz", 2'b00, {o_line_p_oe, o_line_n_oe});
        i_oe_pin <= 1'b1;
        settle();
        chk("global_on", 2'b11, {o_line_p_oe, o_line_n_oe});
    endtask

    task automatic t_oc();
        i_tx_overcurrent <= 1'b1;
        settle();
        chk("limit", 2'b11, {o_current_limit, o_line_p_oe});
        apb(0, txawg_pkg::OFS_LINE_ST, 0);
        chk("oc_state", 32'h0000_0010, rd);
        chk("irq_masked", 0, o_irq);
        apb(1, txawg_pkg::OFS_IRQ_MASK, 32'h0000_0010);
        settle();
        chk("irq_oc", 1, o_irq);
        apb(1, txawg_pkg::OFS_IRQ_FLAG, 32'h0000_0010);
        i_tx_overcurrent <= 1'b0;
        settle();
        apb(0, txawg_pkg::OFS_IRQ_FLAG, 0);
        chk("fall_ignored", 0, rd);
        apb(1, txawg_pkg::OFS_IRQ_EDGE, 32'h0000_0010);
        i_tx_overcurrent <= 1'b1;
        settle();
        apb(1, txawg_pkg::OFS_IRQ_FLAG, 32'h0000_0010);
        apb(1, txawg_pkg::OFS_TXCFG0, 32'h0000_0050);
        settle();
        chk("oc_hiz", 0, o_line_p_oe);
        i_tx_overcurrent <= 1'b0;
        settle();
        apb(0, txawg_pkg::OFS_IRQ_FLAG, 0);
        chk("fall_any_edge", 32'h0000_0010, rd);
        apb(1, txawg_pkg::OFS_IRQ_FLAG, 32'h0000_0010);
        apb(1, txawg_pkg::OFS_IRQ_MASK, 0);
    endtask

    // alternate marks flip polarity, so tail sample 17 of one pulse adds to sample 1 of the next;
    // sample 1 is -63 (left by t_ram) and sample 17 +63, so the flipped tail doubles it
    task automatic t_ovf();
        logic [12:0] pk = '0;
        apb(1, txawg_pkg::OFS_RAM_DATA, 32'h0000_003F);
        apb(1, txawg_pkg::OFS_RAM_CTRL, 32'h0000_0050);
        apb(1, txawg_pkg::OFS_SHAPE, 32'h0000_0008);
        i_tx_mark <= 1'b1;
        repeat (100) begin
            @(posedge i_mclk);
            if ($signed(o_dac_level) > $signed(pk)) begin
                pk = o_dac_level;
            end
        end
        i_tx_mark <= 1'b0;
        chk("dac_peak", 32'(txawg_pkg::AMP_MAX * txawg_pkg::GAIN_RST), pk);
        apb(0, txawg_pkg::OFS_IRQ_FLAG, 0);
        chk("ovf_flag", 32'h0000_0080, rd);
        chk("ovf_irq_off", 0, o_irq);
        apb(1, txawg_pkg::OFS_IRQ_MASK, 32'h0000_0080);
        settle();
        chk("ovf_irq_on", 1, o_irq);
    endtask

    // standard set 4 as editing reference: sample 10 is 5FH
    task automatic t_tpl();
        apb(1, txawg_pkg::OFS_TPL_LOAD, 32'h0000_0004);
        apb(0, txawg_pkg::OFS_TPL_LOAD, 0);
        chk("tpl_index", 32'h0000_0004, rd);
        apb(1, txawg_pkg::OFS_RAM_CTRL, 32'h0000_0069);
        apb(0, txawg_pkg::OFS_RAM_DATA, 0);
        chk("tpl_sample", 32'h0000_005F, rd);
    endtask

    // ==========================================================
    // clock, reset, sequence and verdict
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        failures++;
        end_of_test();
    end

    initial begin
        {i_srst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {i_tx_mark, i_tx_overcurrent} = '0;
        i_srst   = 1'b1;
        i_oe_pin = 1'b1;
        repeat (6) @(posedge i_mclk);
        i_srst <= 1'b0;
        settle();
        t_regs();
        t_ram();
        t_drive();
        t_oc();
        t_ovf();
        t_tpl();
        end_of_test();
    end
endmodule
